// [design/sabrc_ctrl.sv]
// buffer, reference and soft-reset control for the touch-screen converter
// Overview of operation
// R01: buffer enable 0 disables buffering and holds all pointers at reset values.
// R02: shot select 0 means continuous buffering, 1 means single-shot buffering.
// R03: trigger level equals eight times (field plus one), 8 through 64.
// R04: full flag reads 1 exactly when 64 unread results are held.
// R05: empty flag reads 1 when nothing unread remains; resets to 1.
// R06: host always writes 0 to the reserved writable reference bit.
// R07: reference source 0 selects external pin, 1 selects internal reference.
// R08: settle delay codes give 0, 100, 500, 1000 us waits.
// R09: settle delay applies only with internal reference sleeping between conversions.
// R10: sleep select 0 keeps reference powered, 1 sleeps between conversions.
// R11: external reference selected keeps internal reference powered down always.
// R12: level bit selects 1.25 V when 0, 2.50 V when 1.
// R13: writing 0xBB00 to reset register restores all control registers' defaults; code leaves the reset register at 0xBB00, not 0xFFFF.
// R14: host writes no value other than the reset code there.
// R15: while buffering, channel new-data and data-available status are invalid.
// R16: unread count rises per stored result, falls per read; trigger at level.
module sabrc_ctrl #(
  parameter int depth        = sabrc_pkg::buf_depth,
  parameter int dly_01_cycles = sabrc_pkg::delay_01_cyc,
  parameter int dly_10_cycles = sabrc_pkg::delay_10_cyc,
  parameter int dly_11_cycles = sabrc_pkg::delay_11_cyc
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // register port
  input  wire sabrc_pkg::sabrc_req_type req,
  output logic [15:0]                  rdata,
  // converter side
  input  wire logic                    result_store,
  input  wire logic                    result_read,
  input  wire logic                    conv_request,
  output logic                         conv_start,
  output logic                         settling,
  // buffer state
  output logic                         buffer_mode,
  output logic                         single_shot,
  output logic                         trigger_event,
  output logic [5:0]                   read_pointer,
  output logic [5:0]                   write_pointer,
  output logic [5:0]                   trigger_pointer,
  output logic                         status_valid,
  // reference steering
  output sabrc_pkg::sabrc_ref_type     ref_ctrl
);

  typedef enum logic [1:0] {st_idle, st_wait, st_go} sabrc_state_type;

  logic            buf_enable;
  logic            buf_shot;
  logic [2:0]      tl_code;
  logic            ref_rsvd;
  logic            ref_src;
  logic [1:0]      ref_dly;
  logic            ref_sleep;
  logic            ref_level;
  logic [15:0]     reset_word;
  logic [6:0]      unread;
  logic [16:0]     wait_cnt;
  logic [16:0]     next_wait;
  sabrc_state_type state;
  logic            soft_reset;
  logic            clear_regs;
  logic            buf_wr;
  logic            ref_wr;
  logic            rst_wr;
  logic            store_ok;
  logic            read_ok;
  logic            hold_ptrs;
  logic            trig_hit;
  logic            need_wait;
  logic [6:0]      trig_level;
  logic            full_flag;
  logic            empty_flag;
  logic [15:0]     buf_word;
  logic [15:0]     ref_word;
  logic [15:0]     next_rdata;

  // write decode shared by all three registers
  function automatic logic write_hit(input sabrc_pkg::sabrc_req_type r, input logic [6:0] a);
    write_hit = r.wr && r.addr == a;
  endfunction

  // settle wait in clock cycles for a delay code
  function automatic logic [16:0] settle_cycles(input logic [1:0] code);
    unique case (code)
      2'b00: settle_cycles = 17'h00000;
      2'b01: settle_cycles = 17'(dly_01_cycles);
      2'b10: settle_cycles = 17'(dly_10_cycles);
      2'b11: settle_cycles = 17'(dly_11_cycles);
    endcase
  endfunction

  assign buf_wr     = write_hit(req, sabrc_pkg::buf_ctrl_addr);
  assign ref_wr     = write_hit(req, sabrc_pkg::ref_ctrl_addr);
  assign rst_wr     = write_hit(req, sabrc_pkg::reset_ctrl_addr);
  assign soft_reset = rst_wr && req.wdata == sabrc_pkg::soft_reset_code; // [R13] [R14]
  assign clear_regs = srst || soft_reset; // [R13]

  // buffer control fields
  always_ff @(posedge clk) begin
    if (clear_regs) begin
      buf_enable <= sabrc_pkg::buf_ctrl_reset[sabrc_pkg::buf_enable_bit]; // [R13]
    end else if (buf_wr) begin
      buf_enable <= req.wdata[sabrc_pkg::buf_enable_bit]; // [R01]
    end
  end

  always_ff @(posedge clk) begin
    if (clear_regs) begin
      buf_shot <= sabrc_pkg::buf_ctrl_reset[sabrc_pkg::buf_shot_bit]; // [R13]
    end else if (buf_wr) begin
      buf_shot <= req.wdata[sabrc_pkg::buf_shot_bit]; // [R02]
    end
  end

  always_ff @(posedge clk) begin
    if (clear_regs) begin
      tl_code <= sabrc_pkg::buf_ctrl_reset[sabrc_pkg::buf_tl_lsb +: 3]; // [R13]
    end else if (buf_wr) begin
      tl_code <= req.wdata[sabrc_pkg::buf_tl_lsb +: 3]; // [R03]
    end
  end

  // reference control fields, reserved writable bit kept as written
  always_ff @(posedge clk) begin
    if (clear_regs) begin
      ref_rsvd <= sabrc_pkg::ref_ctrl_reset[sabrc_pkg::ref_rsvd_bit]; // [R13]
    end else if (ref_wr) begin
      ref_rsvd <= req.wdata[sabrc_pkg::ref_rsvd_bit]; // [R06]
    end
  end

  always_ff @(posedge clk) begin
    if (clear_regs) begin
      ref_src <= sabrc_pkg::ref_ctrl_reset[sabrc_pkg::ref_src_bit]; // [R13]
    end else if (ref_wr) begin
      ref_src <= req.wdata[sabrc_pkg::ref_src_bit]; // [R07]
    end
  end

  always_ff @(posedge clk) begin
    if (clear_regs) begin
      ref_dly <= sabrc_pkg::ref_ctrl_reset[sabrc_pkg::ref_dly_lsb +: 2]; // [R13]
    end else if (ref_wr) begin
      ref_dly <= req.wdata[sabrc_pkg::ref_dly_lsb +: 2]; // [R08]
    end
  end

  always_ff @(posedge clk) begin
    if (clear_regs) begin
      ref_sleep <= sabrc_pkg::ref_ctrl_reset[sabrc_pkg::ref_sleep_bit]; // [R10] [R13]
    end else if (ref_wr) begin
      ref_sleep <= req.wdata[sabrc_pkg::ref_sleep_bit]; // [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (clear_regs) begin
      ref_level <= sabrc_pkg::ref_ctrl_reset[sabrc_pkg::ref_level_bit]; // [R13]
    end else if (ref_wr) begin
      ref_level <= req.wdata[sabrc_pkg::ref_level_bit]; // [R12]
    end
  end

  // reset word reads back its last value
  always_ff @(posedge clk) begin
    if (srst) begin
      reset_word <= sabrc_pkg::reset_word_reset;
    end else if (rst_wr) begin
      reset_word <= req.wdata;
    end
  end

  assign buffer_mode  = buf_enable; // [R01]
  assign single_shot  = buf_shot; // [R02]
  assign status_valid = !buf_enable; // [R15]
  assign trig_level   = 7'((tl_code + 4'h1) * sabrc_pkg::tl_step); // [R03]
  assign full_flag    = unread == 7'(depth); // [R04]
  assign empty_flag   = unread == 7'h00; // [R05]
  assign hold_ptrs    = clear_regs || !buf_enable; // [R01]
  assign store_ok     = buf_enable && result_store && !full_flag;
  assign read_ok      = buf_enable && result_read && !empty_flag;
  assign trig_hit     = store_ok && 7'(unread + 7'h01) == trig_level; // [R16]

  // unread count, a store and a read in one cycle cancel
  always_ff @(posedge clk) begin
    if (hold_ptrs) begin
      unread <= 7'h00; // [R01] [R05]
    end else if (store_ok && !read_ok) begin
      unread <= unread + 7'h01; // [R16]
    end else if (read_ok && !store_ok) begin
      unread <= unread - 7'h01; // [R16]
    end
  end

  // pointers wrap over the 64 entries
  always_ff @(posedge clk) begin
    if (hold_ptrs) begin
      write_pointer <= 6'h00; // [R01]
    end else if (store_ok) begin
      write_pointer <= write_pointer + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (hold_ptrs) begin
      read_pointer <= 6'h00; // [R01]
    end else if (read_ok) begin
      read_pointer <= read_pointer + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (hold_ptrs) begin
      trigger_pointer <= 6'h00; // [R01]
    end else if (trig_hit) begin
      trigger_pointer <= write_pointer + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (hold_ptrs) begin
      trigger_event <= 1'b0;
    end else begin
      trigger_event <= trig_hit; // [R16]
    end
  end

  // reference steering, an external source keeps the internal one off
  assign ref_ctrl.internal_sel     = ref_src; // [R07]
  assign ref_ctrl.level_2v5        = ref_level; // [R12]
  assign ref_ctrl.internal_powered = ref_src && (!ref_sleep || state != st_idle); // [R10] [R11]
  assign next_wait                 = settle_cycles(ref_dly); // [R08]
  assign need_wait                 = ref_src && ref_sleep && next_wait != 17'h00000; // [R09]

  // settle sequencer, waits only for a sleeping internal reference
  always_ff @(posedge clk) begin
    if (clear_regs) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          if (conv_request && need_wait) begin // [R09]
            state <= st_wait;
          end else if (conv_request) begin
            state <= st_go;
          end
        end
        st_wait: begin
          if (wait_cnt == 17'h00001) begin
            state <= st_go;
          end
        end
        st_go: begin
          state <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (clear_regs) begin
      wait_cnt <= 17'h00000;
    end else if (state == st_idle && conv_request && need_wait) begin
      wait_cnt <= next_wait; // [R08]
    end else if (state == st_wait) begin
      wait_cnt <= wait_cnt - 17'h00001;
    end
  end

  assign settling   = state == st_wait;
  assign conv_start = state == st_go;

  assign buf_word = {buf_enable, buf_shot, tl_code, full_flag, empty_flag, 9'h000}; // [R04] [R05]
  assign ref_word = {10'h000, ref_rsvd, ref_src, ref_dly, ref_sleep, ref_level};

  // read data mux, unmapped addresses read as zero
  always_comb begin
    unique case (req.addr)
      sabrc_pkg::buf_ctrl_addr:   next_rdata = buf_word;
      sabrc_pkg::ref_ctrl_addr:   next_rdata = ref_word;
      sabrc_pkg::reset_ctrl_addr: next_rdata = reset_word;
      default:                    next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end
  end

endmodule

// [shared/sabrc_pkg.sv]
// register map, field layout and timing constants for the buffer/reference control block
package sabrc_pkg;

  // register offsets (word addresses on the register port)
  localparam logic [6:0] buf_ctrl_addr  = 7'h02;
  localparam logic [6:0] ref_ctrl_addr  = 7'h03;
  localparam logic [6:0] reset_ctrl_addr = 7'h04;

  // result buffer control field positions
  localparam int buf_enable_bit = 15;
  localparam int buf_shot_bit   = 14;
  localparam int buf_tl_lsb     = 11;
  localparam int buf_full_bit   = 10;
  localparam int buf_empty_bit  = 9;

  // reference control field positions
  localparam int ref_rsvd_bit   = 5;
  localparam int ref_src_bit    = 4;
  localparam int ref_dly_lsb    = 2;
  localparam int ref_sleep_bit  = 1;
  localparam int ref_level_bit  = 0;

  // reset values
  localparam logic [15:0] buf_ctrl_reset  = 16'h0200;
  localparam logic [15:0] ref_ctrl_reset  = 16'h0002;
  localparam logic [15:0] reset_word_reset = 16'hffff;
  localparam logic [15:0] soft_reset_code = 16'hbb00;

  // buffer geometry
  localparam int          buf_depth      = 64;
  localparam int          tl_step        = 8;

  // settling delays in microseconds and cycles at 100 MHz
  localparam int clk_mhz       = 100;
  localparam int delay_01_us   = 100;
  localparam int delay_10_us   = 500;
  localparam int delay_11_us   = 1000;
  localparam int delay_01_cyc  = delay_01_us * clk_mhz;
  localparam int delay_10_cyc  = delay_10_us * clk_mhz;
  localparam int delay_11_cyc  = delay_11_us * clk_mhz;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } sabrc_req_type;

  // reference steering outputs
  typedef struct packed {
    logic internal_sel;
    logic internal_powered;
    logic level_2v5;
  } sabrc_ref_type;

endpackage

// [tb/sabrc_checker.sv]
// port assertions for the buffer/reference control block
module sabrc_checker (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     srst,
  // register port
  input wire sabrc_pkg::sabrc_req_type req,
  input wire logic [15:0]              rdata,
  // converter side and state
  input wire logic                     conv_start,
  input wire logic                     settling,
  input wire logic                     buffer_mode,
  input wire logic                     single_shot,
  input wire logic [5:0]               read_pointer,
  input wire logic [5:0]               write_pointer,
  input wire logic [5:0]               trigger_pointer,
  input wire logic                     status_valid,
  input wire sabrc_pkg::sabrc_ref_type ref_ctrl
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic wr2;
  assign wr2 = req.wr && req.addr == sabrc_pkg::buf_ctrl_addr;
  chk_buf_write: assert property (wr2 |=>
    buffer_mode == $past(req.wdata[15]) && single_shot == $past(req.wdata[14])) else $error("mode bits lost");
  chk_ptr_hold: assert property (!buffer_mode && $past(!buffer_mode) |->
    (read_pointer | write_pointer | trigger_pointer) == 6'h00) else $error("pointers moved");
  chk_status_inv: assert property (status_valid != buffer_mode) else $error("status validity wrong");
  chk_ext_off: assert property (!ref_ctrl.internal_sel |-> !ref_ctrl.internal_powered)
    else $error("internal ref powered");
  chk_start_once: assert property (conv_start |=> !conv_start) else $error("start too long");
  chk_settle_end: assert property ($fell(settling) && !$past(req.wr) |-> conv_start)
    else $error("no start after settle");
  chk_settle_need: assert property (settling |-> ref_ctrl.internal_sel) else $error("settle on ext ref");
  chk_rdata_hold: assert property (!$past(req.rd) |-> $stable(rdata)) else $error("rdata changed");
  cover property ($rose(buffer_mode));
  cover property ($fell(settling));
  cover property (conv_start && !ref_ctrl.internal_sel);
endmodule
bind sabrc_ctrl sabrc_checker sabrc_checker_inst (.clk, .srst, .req, .rdata, .conv_start, .settling,
  .buffer_mode, .single_shot, .read_pointer, .write_pointer, .trigger_pointer, .status_valid, .ref_ctrl);

// [tb/sabrc_host.sv]
// host model driving the register port
module sabrc_host (
  // clock
  input  wire logic                 clk,
  // register port
  output sabrc_pkg::sabrc_req_type  req,
  input  wire logic [15:0]          rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    if (a == 7'h04 && d !== sabrc_pkg::soft_reset_code) return;
    if (a == 7'h03) d[5] = 1'b0;
    @(posedge clk) #1 req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) #1 req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    @(posedge clk) #1 req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk) #1 req.rd <= 1'b0;
    q = rdata;
  endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the buffer/reference control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, result_store = 1'b0, result_read = 1'b0, conv_request = 1'b0, seen = 1'b0;
  logic conv_start, settling, buffer_mode, single_shot, trigger_event, status_valid;
  logic [5:0] read_pointer, write_pointer, trigger_pointer;
  logic [15:0] rdata, q, w;
  logic [6:0] addrs [4] = '{7'h02, 7'h03, 7'h04, 7'h11};
  logic [15:0] resets [4] = '{16'h0200, 16'h0002, 16'hffff, 16'h0000};
  int errors = 0, n_compared = 0;
  sabrc_pkg::sabrc_req_type req;
  sabrc_pkg::sabrc_ref_type ref_ctrl;
  always #5 clk = ~clk;
  always @(posedge clk) if (trigger_event) seen <= 1'b1;
  sabrc_ctrl #(.dly_01_cycles(5), .dly_10_cycles(10), .dly_11_cycles(20)) sabrc_ctrl_inst (.clk, .srst, .req,
    .rdata, .result_store, .result_read, .conv_request, .conv_start, .settling, .buffer_mode, .single_shot,
    .trigger_event, .read_pointer, .write_pointer, .trigger_pointer, .status_valid, .ref_ctrl);
  sabrc_host sabrc_host_inst (.clk, .req, .rdata);
  task automatic chk(input logic [15:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // n back-to-back store (r=0) or pop (r=1) pulses
  task automatic drive(input int n, input bit r);
    @(posedge clk) #1;
    if (r) result_read = 1'b1;
    else result_store = 1'b1;
    repeat (n) @(posedge clk);
    #1 result_read = 1'b0;
    result_store = 1'b0;
  endtask
  function automatic int wait_cyc(input logic [15:0] r);
    if (!(r[4] && r[1])) return 0;
    return r[3:2] == 2'd0 ? 0 : r[3:2] == 2'd1 ? 5 : r[3:2] == 2'd2 ? 10 : 20;
  endfunction
  // pointer after n fill rounds of 8, 16, ... entries, wrapping at 64
  function automatic logic [5:0] ptr_at(input int n);
    return 6'(4 * n * (n + 1));
  endfunction
  task automatic settle(input logic [15:0] r);
    int k;
    sabrc_host_inst.wr(7'h03, r);
    chk(ref_ctrl.level_2v5, r[0], "level");
    chk(ref_ctrl.internal_sel, r[4], "source");
    chk(ref_ctrl.internal_powered, r[4] & ~r[1], "power");
    repeat (3) @(posedge clk);
    #1 conv_request = 1'b1;
    @(posedge clk) #1 conv_request = 1'b0;
    chk(settling, wait_cyc(r) != 0, "settling");
    chk(ref_ctrl.internal_powered, r[4], "power up");
    k = 1;
    while (!conv_start && k < 40) begin
      @(posedge clk) #1 k++;
    end
    chk(16'(k), 16'(wait_cyc(r) + 1), "settle");
    if (k >= 40) close_out();
  endtask
  task automatic rtable;
    foreach (addrs[i]) begin
      sabrc_host_inst.rd(addrs[i], q);
      chk(q, resets[i], "register value");
    end
  endtask
  initial begin
    void'($urandom(32'hb406));
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    sabrc_host_inst.wr(7'h04, 16'h1234);
    rtable();
    for (int c = 0; c < 8; c++) begin
      w = {1'b1, 1'($urandom), 3'(c), 11'($urandom)};
      sabrc_host_inst.wr(7'h02, w);
      chk(buffer_mode, 1'b1, "mode");
      chk(single_shot, w[14], "shot");
      chk(status_valid, 1'b0, "status");
      seen = 1'b0;
      drive(8 * (c + 1) - 1, 0);
      #21 chk(seen, 1'b0, "early trigger");
      drive(1, 0);
      #21 chk(seen, 1'b1, "trigger");
      sabrc_host_inst.rd(7'h02, q);
      chk(q[10:9], {c == 7, 1'b0}, "flags");
      chk(16'(write_pointer), 16'(ptr_at(c + 1)), "write pointer");
      drive(8 * (c + 1), 1);
      sabrc_host_inst.rd(7'h02, q);
      chk(q, {w[15:11], 11'h200}, "drained");
      chk(16'(read_pointer), 16'(ptr_at(c + 1)), "read pointer");
    end
    sabrc_host_inst.wr(7'h02, 16'h4000);
    drive(3, 0);
    chk(16'(read_pointer | write_pointer | trigger_pointer), 16'h0000, "pointers");
    sabrc_host_inst.rd(7'h02, q);
    chk(q, 16'h4200, "disabled");
    chk(buffer_mode, 1'b0, "mode off");
    for (int c = 0; c < 4; c++) settle({10'h0, 1'b0, 1'b1, 2'(c), 1'b1, 1'($urandom)});
    settle({11'h0, 1'b1, 2'd3, 1'b0, 1'b1});
    settle({11'h0, 1'b0, 2'd3, 1'b1, 1'b0});
    sabrc_host_inst.wr(7'h02, 16'hf800);
    sabrc_host_inst.wr(7'h04, sabrc_pkg::soft_reset_code);
    resets[2] = 16'hbb00;
    rtable();
    close_out();
  end
endmodule
